// ---- irq_flag_pkg.sv ----
// constants, register map and carrier types of the interrupt flag logic
// assumes a 10 MHz system clock and a 32-bit avalon-mm register port
package irq_flag_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int NR_TIME_NS = 1000000; // 1 ms longest noise-rejector delay
  localparam int NR_CYCLES = NR_TIME_NS / CLK_PERIOD_NS; // rounded down
  localparam int SYNC_STAGES = 2;
  localparam int ENTRY_CYCLES = 12; // accept to vector in program counter
  localparam int PUSH_WORDS = 3;

  // widths
  localparam int NUM_PINS = 5;
  localparam int ADDR_W = 5;

  // register byte offsets
  localparam logic [4:0] OFS_MASK = 5'h00;
  localparam logic [4:0] OFS_EDGE = 5'h04;
  localparam logic [4:0] OFS_FLAGS = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_CTRL = 5'h10;

  // field positions
  localparam int MASK_CT_BIT = 8;
  localparam int MASK_SW_BIT = 9;
  localparam int FLAG_INPUT_BIT = 0;
  localparam int FLAG_CT_BIT = 1;
  localparam int FLAG_SW_BIT = 2;
  localparam int STAT_IE_BIT = 0;
  localparam int STAT_REQ_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_HOLD_BIT = 3;
  localparam int STAT_PINS_LSB = 4;
  localparam int CTRL_NR_BIT = 0;

  // reset values
  localparam logic [4:0] RST_MASK_K = 5'h00;
  localparam logic [4:0] RST_EDGE = 5'h1F; // falling edge on every pin
  localparam logic RST_NR_EN = 1'b0;

  // vectors of the three sources, values arbitrary
  localparam logic [7:0] VEC_INPUT = 8'h0C;
  localparam logic [7:0] VEC_STOPWATCH = 8'h08;
  localparam logic [7:0] VEC_CLOCK_TIMER = 8'h04;

  typedef enum logic [0:0] {ENTRY_IDLE, ENTRY_RUN} entry_state_t;

  // avalon-mm request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avmm_req_t;

  // stack and vector side of interrupt entry
  typedef struct packed {
    logic push_wr;
    logic [3:0] push_data;
    logic vec_load;
    logic [7:0] vector;
  } entry_out_t;

endpackage : irq_flag_pkg

// ---- pin_sync.sv ----
// two-stage synchroniser for the input port pins
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import irq_flag_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [NUM_PINS-1:0] pin_async,
  output logic [NUM_PINS-1:0] pin_sync_out
);

  typedef struct packed {
    logic [NUM_PINS-1:0] meta;
    logic [NUM_PINS-1:0] stable;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // first stage feeds only the second
  always_comb begin
    next_st.meta = pin_async;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign pin_sync_out = st.stable;

endmodule : pin_sync
`default_nettype wire

// ---- noise_reject.sv ----
// noise rejector of one input pin: passes a level once it has stood still
// assumes a synchronised input; bypassed when not enabled
`timescale 1ns/1ps
`default_nettype none
module noise_reject
  import irq_flag_pkg::*;
#(
  parameter logic [15:0] LIMIT = 16'(NR_CYCLES - SYNC_STAGES - 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic pin_in,
  output logic pin_out
);

  typedef struct packed {
    logic level;
    logic [15:0] cnt;
  } nr_state_t;

  nr_state_t st;
  nr_state_t next_st;

  // count while input differs from the held level, take it at the limit
  always_comb begin
    next_st = st;
    if (!enable || pin_in == st.level) begin
      next_st.cnt = '0;
      next_st.level = pin_in;
    end else if (st.cnt >= LIMIT) begin
      next_st.cnt = '0;
      next_st.level = pin_in;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // bypass keeps full speed when the rejector is off
  assign pin_out = enable ? st.level : pin_in;

  // the held level never trails a steady input beyond the limit
  a_nr_bound: assert property (@(posedge clk) disable iff (rst || !ce)
    (enable && pin_in != st.level) |-> st.cnt <= LIMIT)
    else $error("noise rejector count passed its limit");

endmodule : noise_reject
`default_nettype wire

// ---- irq_flag_logic.sv ----
// interrupt factor flags, masks, request and entry sequencing of the cpu
// assumes cpu strobes on clk, timer signals on clk, pins asynchronous
`timescale 1ns/1ps
`default_nettype none
module irq_flag_logic
  import irq_flag_pkg::*;
#(
  parameter logic [15:0] NR_LIMIT = 16'(NR_CYCLES - SYNC_STAGES - 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire avmm_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // input port pins
  input wire logic [NUM_PINS-1:0] key_pins,
  // timer sources
  input wire logic clock_timer_signal,
  input wire logic clock_timer_reset,
  input wire logic stopwatch_overflow,
  // cpu side
  input wire logic interrupts_enabled_state,
  input wire logic interrupts_disabled_state,
  input wire logic page_preset_instruction,
  input wire logic branch_done,
  input wire logic irq_take,
  input wire logic [11:0] cpu_pc,
  output logic irq_req,
  output logic interrupt_enable,
  output entry_out_t entry
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [NUM_PINS-1:0] input_mask;
    logic clock_timer_irq_mask;
    logic stopwatch_irq_mask;
    logic [NUM_PINS-1:0] edge_sel;
    logic nr_en;
    logic input_port_flag;
    logic clock_timer_flag;
    logic stopwatch_flag;
    logic [NUM_PINS-1:0] act_prev;
    logic ct_prev;
    logic ie;
    logic hold;
    entry_state_t fsm;
    logic [3:0] cnt;
    logic [11:0] pc_cap;
    entry_out_t eo;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;

  logic [NUM_PINS-1:0] pin_s;
  logic [NUM_PINS-1:0] pin_f;
  logic [NUM_PINS-1:0] act_m;
  logic [NUM_PINS-1:0] in_set;
  logic ct_set;
  logic sw_set;
  logic pending;
  logic accept;
  logic rd_cap;
  logic wr_go;
  logic flag_read;

  // synchronise and optionally filter the pins
  pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin_async(key_pins),
    .pin_sync_out(pin_s)
  );

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_nr
    noise_reject #(.LIMIT(NR_LIMIT)) u_nr (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .enable(st.nr_en),
      .pin_in(pin_s[i]),
      .pin_out(pin_f[i])
    );
  end

  // readback value of one register
  function automatic logic [31:0] reg_value(input core_state_t s, input logic [4:0] a,
                                             input logic [NUM_PINS-1:0] pins, input logic req);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFS_MASK: begin
        v[NUM_PINS-1:0] = s.input_mask;
        v[MASK_CT_BIT] = s.clock_timer_irq_mask;
        v[MASK_SW_BIT] = s.stopwatch_irq_mask;
      end
      OFS_EDGE: v[NUM_PINS-1:0] = s.edge_sel;
      OFS_FLAGS: begin
        v[FLAG_INPUT_BIT] = s.input_port_flag;
        v[FLAG_CT_BIT] = s.clock_timer_flag;
        v[FLAG_SW_BIT] = s.stopwatch_flag;
      end
      OFS_STATUS: begin
        v[STAT_IE_BIT] = s.ie;
        v[STAT_REQ_BIT] = req;
        v[STAT_BUSY_BIT] = (s.fsm == ENTRY_RUN);
        v[STAT_HOLD_BIT] = s.hold;
        v[STAT_PINS_LSB +: NUM_PINS] = pins;
      end
      OFS_CTRL: v[CTRL_NR_BIT] = s.nr_en;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_value

  // event detection: active level is low for falling, high for rising
  assign act_m = st.input_mask & (pin_f ^ st.edge_sel);
  assign in_set = act_m & ~st.act_prev;
  assign ct_set = (st.ct_prev && !clock_timer_signal)
                  || (st.ct_prev && clock_timer_reset);
  assign sw_set = stopwatch_overflow;

  // request gating
  assign pending = (st.input_port_flag && (|st.input_mask))
                   || (st.clock_timer_flag && st.clock_timer_irq_mask)
                   || (st.stopwatch_flag && st.stopwatch_irq_mask);
  assign irq_req = pending && st.ie && !st.hold && (st.fsm == ENTRY_IDLE);
  assign accept = irq_req && irq_take;

  // bus handshake: one wait state, read data and read clear on the first cycle, writes on the second
  assign rd_cap = avs_req.read && !st.ack;
  assign wr_go = avs_req.write && st.ack;
  assign flag_read = rd_cap && (avs_req.address == OFS_FLAGS);
  assign avs_waitrequest = (avs_req.read || avs_req.write) && !st.ack;

  always_comb begin
    next_st = st;
    next_st.ack = (avs_req.read || avs_req.write) && !st.ack;
    next_st.eo.push_wr = 1'b0;
    next_st.eo.vec_load = 1'b0;
    if (rd_cap) begin
      next_st.rdata = reg_value(st, avs_req.address, pin_f, irq_req);
    end
    // register writes
    if (wr_go) begin
      case (avs_req.address)
        OFS_MASK: begin
          if (avs_req.byteenable[0]) begin
            next_st.input_mask = avs_req.writedata[NUM_PINS-1:0];
          end
          if (avs_req.byteenable[1]) begin
            next_st.clock_timer_irq_mask = avs_req.writedata[MASK_CT_BIT];
            next_st.stopwatch_irq_mask = avs_req.writedata[MASK_SW_BIT];
          end
        end
        OFS_EDGE: begin
          if (avs_req.byteenable[0]) begin
            next_st.edge_sel = avs_req.writedata[NUM_PINS-1:0];
          end
        end
        OFS_CTRL: begin
          if (avs_req.byteenable[0]) begin
            next_st.nr_en = avs_req.writedata[CTRL_NR_BIT];
          end
        end
        default: next_st.nr_en = st.nr_en;
      endcase
    end
    // edge history
    next_st.act_prev = act_m;
    next_st.ct_prev = clock_timer_signal;
    // factor flags: read clears, a set in the same cycle wins
    next_st.input_port_flag = (st.input_port_flag && !flag_read) || (|in_set);
    next_st.clock_timer_flag = (st.clock_timer_flag && !flag_read) || ct_set;
    next_st.stopwatch_flag = (st.stopwatch_flag && !flag_read) || sw_set;
    // page preset hold until the branch completes
    if (page_preset_instruction) begin
      next_st.hold = 1'b1;
    end else if (branch_done) begin
      next_st.hold = 1'b0;
    end
    // cpu interrupt enable flag
    if (interrupts_enabled_state) begin
      next_st.ie = 1'b1;
    end
    if (interrupts_disabled_state) begin
      next_st.ie = 1'b0;
    end
    // entry sequence
    case (st.fsm)
      ENTRY_IDLE: begin
        if (accept) begin
          next_st.ie = 1'b0;
          next_st.fsm = ENTRY_RUN;
          next_st.cnt = 4'h1;
          next_st.pc_cap = cpu_pc;
          if (st.input_port_flag && (|st.input_mask)) begin
            next_st.eo.vector = VEC_INPUT;
          end else if (st.stopwatch_flag && st.stopwatch_irq_mask) begin
            next_st.eo.vector = VEC_STOPWATCH;
          end else begin
            next_st.eo.vector = VEC_CLOCK_TIMER;
          end
        end
      end
      ENTRY_RUN: begin
        next_st.cnt = st.cnt + 4'h1;
        // three stack words: page, step high, step low
        if (st.cnt <= 4'(PUSH_WORDS)) begin
          next_st.eo.push_wr = 1'b1;
          case (st.cnt)
            4'h1: next_st.eo.push_data = st.pc_cap[11:8];
            4'h2: next_st.eo.push_data = st.pc_cap[7:4];
            default: next_st.eo.push_data = st.pc_cap[3:0];
          endcase
        end
        if (st.cnt == 4'(ENTRY_CYCLES - 1)) begin
          next_st.eo.vec_load = 1'b1;
          next_st.fsm = ENTRY_IDLE;
          next_st.cnt = 4'h0;
        end
      end
      default: next_st.fsm = ENTRY_IDLE;
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.input_mask <= RST_MASK_K;
      st.edge_sel <= RST_EDGE;
      st.nr_en <= RST_NR_EN;
      st.fsm <= ENTRY_IDLE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.rdata;
  assign interrupt_enable = st.ie;
  assign entry = st.eo;

  // vector reaches the program counter twelve cycles after accept
  a_vec_timing: assert property (@(posedge clk) disable iff (rst || !ce)
    accept |-> ##12 entry.vec_load)
    else $error("vector not loaded twelve cycles after accept");

  // exactly three stack words follow an accept
  a_push_three: assert property (@(posedge clk) disable iff (rst || !ce)
    accept |-> ##2 entry.push_wr [*3] ##1 !entry.push_wr)
    else $error("interrupt entry did not push three words");

  // enable flag drops after accept
  a_ie_cleared: assert property (@(posedge clk) disable iff (rst || !ce)
    accept |=> !interrupt_enable)
    else $error("enable flag still set after accept");

  // no request while a page preset waits for its branch
  a_page_preset_instruction_block: assert property (@(posedge clk) disable iff (rst || !ce)
    (page_preset_instruction || (st.hold && !branch_done)) |=> !irq_req)
    else $error("request raised during page preset hold");

  // clock timer falling edge sets its flag regardless of mask
  a_ct_edge: assert property (@(posedge clk) disable iff (rst || !ce)
    $fell(clock_timer_signal) |=> st.clock_timer_flag)
    else $error("clock timer flag missed a falling edge");

  // stopwatch overflow sets its flag regardless of mask
  a_sw_overflow: assert property (@(posedge clk) disable iff (rst || !ce)
    stopwatch_overflow |=> st.stopwatch_flag)
    else $error("stopwatch flag missed an overflow");

  // a flag read with no new event leaves the flags clear
  a_read_clear: assert property (@(posedge clk) disable iff (rst || !ce)
    (flag_read && !ct_set && !sw_set && !(|in_set))
    |=> !st.clock_timer_flag && !st.stopwatch_flag && !st.input_port_flag)
    else $error("factor flags survived a read");

  // a masked active edge on pin 0 raises the input flag
  a_input_edge: assert property (@(posedge clk) disable iff (rst || !ce)
    $rose(act_m[0]) |=> st.input_port_flag)
    else $error("input flag missed an active transition");

  // a timer event under an open mask and enable raises the request next cycle
  a_req_raise: assert property (@(posedge clk) disable iff (rst || !ce)
    (ct_set && st.clock_timer_irq_mask && st.ie && !st.hold && st.fsm == ENTRY_IDLE
     && !accept && !wr_go && !interrupts_disabled_state && !page_preset_instruction)
    |=> irq_req)
    else $error("request missing for enabled pending flag");

endmodule : irq_flag_logic
`default_nettype wire

// ---- cpu_core_model.sv ----
// cpu core model: accepts interrupt requests and collects the stack words
// assumes the entry outputs of the flag logic on the same clk
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
  import irq_flag_pkg::*;
#(
  parameter logic [11:0] PC_VALUE = 12'h5A3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic take_en,
  input wire logic [3:0] take_wait,
  input wire logic irq_req,
  input wire entry_out_t entry,
  output logic irq_take,
  output logic [11:0] cpu_pc,
  output logic [11:0] stacked,
  output logic [7:0] lat
);
  logic [3:0] held;
  logic [7:0] run;

  // program counter stands still while the model waits
  assign cpu_pc = PC_VALUE;

  // takes a request once it has stood take_wait cycles, then times the entry
  always_ff @(posedge clk) begin
    if (rst) begin
      held <= 4'h0;
      irq_take <= 1'b0;
      stacked <= 12'h000;
      run <= 8'h00;
      lat <= 8'h00;
    end else begin
      held <= irq_req ? held + 4'h1 : 4'h0;
      irq_take <= take_en && irq_req && (held >= take_wait);
      if (irq_req && irq_take) begin
        stacked <= 12'h000;
        run <= 8'h00;
      end else begin
        run <= run + 8'h01;
      end
      if (entry.push_wr) begin
        stacked <= {stacked[7:0], entry.push_data};
      end
      if (entry.vec_load) begin
        lat <= run + 8'h01;
      end
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// ---- test_interrupt_flag_logic.sv ----
// self-checking bench of the interrupt flag logic with a cpu core model
// assumes 10 MHz clk, avalon-mm with one wait state, shortened rejector limit
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_flag_logic
  import irq_flag_pkg::*;
;
  localparam logic [15:0] NRL = 16'd4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  avmm_req_t req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq_req;
  logic interrupt_enable;
  logic irq_take;
  logic take_en = 1'b0;
  logic [3:0] take_wait = 4'h0;
  logic [4:0] key = 5'h1F;
  logic ct_sig = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [11:0] cpu_pc;
  logic [11:0] stacked;
  logic [7:0] lat;
  logic [31:0] rdv;
  entry_out_t entry;
  int n_fail = 0;
  int samples_checked = 0;

  // 100 ns clock
  always #50 clk = ~clk;

  // design under test and the cpu on its far side
  irq_flag_logic #(.NR_LIMIT(NRL)) dut_u (
    .clk(clk), .rst(rst), .ce(ce), .avs_req(req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .key_pins(key), .clock_timer_signal(ct_sig),
    .clock_timer_reset(ev[0]), .stopwatch_overflow(ev[1]),
    .interrupts_enabled_state(ev[2]), .interrupts_disabled_state(ev[3]),
    .page_preset_instruction(ev[4]), .branch_done(ev[5]), .irq_take(irq_take),
    .cpu_pc(cpu_pc), .irq_req(irq_req), .interrupt_enable(interrupt_enable),
    .entry(entry)
  );
  cpu_core_model cpu_u (
    .clk(clk), .rst(rst), .take_en(take_en), .take_wait(take_wait), .irq_req(irq_req),
    .entry(entry), .irq_take(irq_take), .cpu_pc(cpu_pc), .stacked(stacked), .lat(lat)
  );

  task automatic final_report;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      chk("wait_bound", 32'h1, 32'h0);
      final_report;
    end
  endtask : bound

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one avalon transfer: held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    req.read <= !wr;
    req.write <= wr;
    req.address <= a;
    req.byteenable <= 4'hF;
    req.writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    bound(n, 20);
    q = avs_readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0, rdv);
    chk(nm, e, rdv);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rdv);
  endtask : wr

  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
  endtask : pulse

  // lets the cpu accept and checks the whole entry sequence
  task automatic take_irq(input logic [3:0] w, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    take_en <= 1'b1;
    take_wait <= w;
    do begin
      @(negedge clk);
      n++;
    end while (entry.vec_load !== 1'b1 && n < 60);
    bound(n, 60);
    @(posedge clk);
    take_en <= 1'b0;
    @(negedge clk);
    chk("entry_cycles", 32'(ENTRY_CYCLES), 32'(lat));
    chk("stack_words", 32'(cpu_pc), 32'(stacked));
    chk("vector", 32'(v), 32'(entry.vector));
    chk("ie_after", 32'h0, 32'(interrupt_enable));
    chk("req_after", 32'h0, 32'(irq_req));
    @(posedge clk);
  endtask : take_irq

  task automatic t_reset;
    rd(OFS_MASK, 32'h0, "mask");
    rd(OFS_EDGE, 32'h1F, "edge");
    rd(OFS_FLAGS, 32'h0, "flags");
    rd(OFS_CTRL, 32'h0, "ctrl");
    wr(5'h14, 32'hFFFFFFFF);
    rd(5'h14, 32'h0, "unmapped");
    rd(OFS_STATUS, 32'h1F0, "status_idle");
    chk("req_reset", 32'h0, 32'(irq_req));
    chk("ie_reset", 32'h0, 32'(interrupt_enable));
  endtask : t_reset

  task automatic t_timers;
    ct_sig <= 1'b1;
    cyc(2);
    ct_sig <= 1'b0;
    pulse(1);
    cyc(3);
    rd(OFS_FLAGS, 32'h6, "timer_flags");
    rd(OFS_FLAGS, 32'h0, "flags_cleared");
    ct_sig <= 1'b1;
    cyc(2);
    pulse(0);
    cyc(2);
    rd(OFS_FLAGS, 32'h2, "timer_reset_flag");
    ct_sig <= 1'b0;
    cyc(2);
    bus(1'b0, OFS_FLAGS, 32'h0, rdv);
  endtask : t_timers

  task automatic t_input;
    wr(OFS_MASK, 32'h1);
    key <= 5'h1E;
    cyc(6);
    rd(OFS_FLAGS, 32'h1, "fall_flag");
    key <= 5'h1F;
    cyc(6);
    rd(OFS_FLAGS, 32'h0, "to_match");
    key <= 5'h1E;
    cyc(6);
    rd(OFS_FLAGS, 32'h1, "fall_again");
    wr(OFS_MASK, 32'h0);
    wr(OFS_MASK, 32'h1);
    rd(OFS_FLAGS, 32'h1, "mask_reset");
    wr(OFS_EDGE, 32'h1E);
    rd(OFS_FLAGS, 32'h0, "to_inactive");
    wr(OFS_EDGE, 32'h1F);
    rd(OFS_FLAGS, 32'h1, "edge_rewrite");
    wr(OFS_MASK, 32'h0);
    wr(OFS_EDGE, 32'h1E);
    wr(OFS_MASK, 32'h1);
    rd(OFS_FLAGS, 32'h0, "rise_idle");
    key <= 5'h1F;
    cyc(6);
    rd(OFS_FLAGS, 32'h1, "rise_flag");
    wr(OFS_MASK, 32'h0);
    wr(OFS_EDGE, 32'h1F);
  endtask : t_input

  task automatic t_noise;
    int n;
    n = 0;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_MASK, 32'h1);
    pulse(2);
    bus(1'b0, OFS_FLAGS, 32'h0, rdv);
    key <= 5'h1E;
    do begin
      @(negedge clk);
      n++;
    end while (irq_req !== 1'b1 && n < 40);
    chk("nr_delay", 32'h1, 32'(n > int'(NRL) && n <= int'(NRL) + 10));
    take_irq(4'h0, VEC_INPUT);
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL, 32'h0);
    key <= 5'h1F;
    cyc(6);
    bus(1'b0, OFS_FLAGS, 32'h0, rdv);
  endtask : t_noise

  task automatic t_hold;
    wr(OFS_MASK, 32'h200);
    pulse(2);
    pulse(4);
    pulse(1);
    cyc(4);
    @(negedge clk);
    chk("req_in_hold", 32'h0, 32'(irq_req));
    rd(OFS_STATUS, 32'h1F9, "status_hold");
    pulse(5);
    @(negedge clk);
    chk("req_after_branch", 32'h1, 32'(irq_req));
    take_irq(4'h3, VEC_STOPWATCH);
    pulse(2);
    @(negedge clk);
    chk("req_reenabled", 32'h1, 32'(irq_req));
    pulse(3);
    @(negedge clk);
    chk("req_disabled", 32'h0, 32'(irq_req));
    rd(OFS_FLAGS, 32'h4, "sw_flag");
    rd(OFS_FLAGS, 32'h0, "sw_cleared");
    // clock timer source with its own mask open
    wr(OFS_MASK, 32'h100);
    pulse(2);
    ct_sig <= 1'b1;
    cyc(2);
    ct_sig <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk("req_timer", 32'h1, 32'(irq_req));
    take_irq(4'h0, VEC_CLOCK_TIMER);
    rd(OFS_FLAGS, 32'h2, "ct_flag");
    wr(OFS_MASK, 32'h0);
  endtask : t_hold

  // with ce low an overflow leaves no trace, with ce high it sets the flag
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    pulse(1);
    cyc(2);
    ce <= 1'b1;
    rd(OFS_FLAGS, 32'h0, "frozen_flags");
    pulse(1);
    rd(OFS_FLAGS, 32'h4, "thawed_flags");
  endtask : t_freeze

  // reset for 16 cycles, then the scenarios in turn
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_timers;
    t_input;
    t_noise;
    t_hold;
    t_freeze;
    final_report;
  end
endmodule : test_interrupt_flag_logic
`default_nettype wire
